/* File: isr_pkg.sv */
// shared constants, register map and types of the i2c register port
package isr_pkg;
  // bus address selected by the strap, 0011010 low and 0011011 high
  localparam logic [6:0]  ADDR_STRAP_LO  = 7'h1a;
  localparam logic [6:0]  ADDR_STRAP_HI  = 7'h1b;
  // address change registers and key
  localparam logic [7:0]  SUB_UNLOCK     = 8'hf8;
  localparam logic [7:0]  SUB_NEW_ADDR   = 8'hf9;
  localparam logic [31:0] UNLOCK_KEY     = 32'hf9a5a5a5;
  // byte counts per subaddress
  localparam logic [7:0]  SUB_WORD_FIRST = 8'h20;
  localparam logic [7:0]  SUB_BQ_FIRST   = 8'h29;
  localparam logic [7:0]  SUB_BQ_LAST    = 8'h36;
  localparam logic [4:0]  LEN_BYTE       = 5'h01;
  localparam logic [4:0]  LEN_WORD       = 5'h04;
  localparam logic [4:0]  LEN_BQ         = 5'h14;
  localparam int          MAX_LEN        = 20;
  // bit clock timing
  localparam int          CLK_HZ         = 40_000_000;
  localparam int          SCL_HZ         = 100_000;
  localparam logic [15:0] SCL_QTR        = 16'(CLK_HZ / (4 * SCL_HZ));
  // host register offsets and fields
  localparam logic [7:0]  HOST_CMD       = 8'h00;
  localparam logic [7:0]  HOST_STAT      = 8'h04;
  localparam logic [7:0]  HOST_DIV       = 8'h08;
  localparam int          CMD_OP_LSB     = 0;
  localparam int          CMD_DATA_LSB   = 8;
  localparam int          CMD_NACK_BIT   = 16;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_ACK_BIT   = 1;
  localparam int          STAT_DATA_LSB  = 8;

  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_STOP  = 2'b01,
    OP_WRITE = 2'b10,
    OP_READ  = 2'b11
  } isr_op_e;

  function automatic logic [4:0] isr_len(input logic [7:0] sub);
    if (sub < SUB_WORD_FIRST)
      return LEN_BYTE;
    else if (sub >= SUB_BQ_FIRST && sub <= SUB_BQ_LAST)
      return LEN_BQ;
    else
      return LEN_WORD;
  endfunction
endpackage

/* File: isr_if.sv */
// two-wire bus between the register port and its bus master
`timescale 1ns/1ps
interface isr_if;
  logic scl;
  logic sda;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;

  // wired-and with pull-ups
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport dev  (input scl, sda, output s_sda_o, s_sda_oe);
  modport host (input scl, sda,
                output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe);
endinterface

/* File: isr_dev.sv */
// i2c slave giving a bus master access to the register space
`timescale 1ns/1ps
module isr_dev
  import isr_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // bus
  isr_if.dev                          bus,
  // address strap pin
  input  wire logic                   adr_sel,
  // register write commit
  output logic                        wr_stb,
  output logic [7:0]                  wr_sub,
  output logic [4:0]                  wr_len,
  output logic [8*MAX_LEN-1:0]        wr_data,
  // register read
  output logic [7:0]                  rd_sub,
  output logic [2:0]                  rd_idx,
  input  wire logic [31:0]            rd_word,
  input  wire logic [5:0]             rd_width,
  // status
  output logic [6:0]                  dev_addr
);
  import isr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_ACK   = 3'b010,
    ST_TX    = 3'b011,
    ST_TXACK = 3'b100,
    ST_SKIP  = 3'b101
  } isr_state_e;

  typedef enum logic [1:0] {
    RO_ADR = 2'b00,
    RO_SUB = 2'b01,
    RO_DAT = 2'b10
  } isr_role_e;

  isr_state_e            state_r;
  isr_role_e             role_r;
  logic [3:0]            bitc_r;
  logic [7:0]            sh_r;
  logic [7:0]            tx_r;
  logic                  rd_mode_r;
  logic [7:0]            sub_r;
  logic [4:0]            cnt_r;
  logic [8*MAX_LEN-1:0]  buf_r;
  logic                  sda_oe_r;
  logic                  acked_r;
  logic [6:0]            addr_r;
  logic                  unlock_r;
  logic                  wr_stb_r;
  logic [7:0]            wr_sub_r;
  logic [4:0]            wr_len_r;
  logic [8*MAX_LEN-1:0]  wr_data_r;
  logic                  scl_s1_r, scl_s2_r, scl_d_r;
  logic                  sda_s1_r, sda_s2_r, sda_d_r;
  logic                  adr_s1_r, adr_s2_r;
  logic [1:0]            strap_cnt_r;

  // pins pass two flops before any logic looks at them
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
      {adr_s1_r, adr_s2_r}          <= 2'h0;
    end
    else
    begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {bus.scl, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {bus.sda, sda_s1_r, sda_s2_r};
      {adr_s1_r, adr_s2_r}          <= {adr_sel, adr_s1_r};
    end

  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  wire bus_start = scl_s2_r & scl_d_r & ~sda_s2_r & sda_d_r;
  wire bus_stop  = scl_s2_r & scl_d_r & sda_s2_r & ~sda_d_r;

  wire [4:0] len_w     = isr_len(sub_r);
  wire       set_done  = (cnt_r == len_w - 5'h01);
  wire       byte_done = scl_fall && (bitc_r == 4'h8);
  wire       adr_hit   = (sh_r[7:1] == addr_r);
  wire [8*MAX_LEN-1:0] buf_nxt = {buf_r[8*MAX_LEN-9:0], sh_r};

  wire [31:0] rd_mask   = (rd_width >= 6'h20) ? 32'hffffffff :
                          ((32'h1 << rd_width) - 32'h1);
  wire [31:0] rd_masked = rd_word & rd_mask;
  // four byte words msb first, single byte low lane
  wire [7:0]  tx_byte   = (len_w == LEN_BYTE) ? rd_masked[7:0] :
                          rd_masked[{~cnt_r[1:0], 3'b000} +: 8];

  wire key_hit  = (sub_r == SUB_UNLOCK) && (buf_nxt[31:0] == UNLOCK_KEY);
  wire addr_new = (sub_r == SUB_NEW_ADDR) && unlock_r;

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      strap_cnt_r <= 2'h0;
      addr_r      <= ADDR_STRAP_LO;
      unlock_r    <= 1'b0;
    end
    else if (strap_cnt_r != 2'h3)
    begin
      // strap caught once the sync chain is filled
      strap_cnt_r <= strap_cnt_r + 2'h1;
      addr_r      <= adr_s2_r ? ADDR_STRAP_HI : ADDR_STRAP_LO;
    end
    else if (state_r == ST_RX && role_r == RO_DAT && byte_done &&
             set_done)
    begin
      if (key_hit)
        unlock_r <= 1'b1;
      else if (addr_new)
      begin
        addr_r   <= buf_nxt[6:0];
        unlock_r <= 1'b0;
      end
    end

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      state_r   <= ST_IDLE;
      role_r    <= RO_ADR;
      bitc_r    <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      rd_mode_r <= 1'b0;
      sub_r     <= 8'h00;
      cnt_r     <= 5'h00;
      buf_r     <= '0;
      sda_oe_r  <= 1'b0;
      acked_r   <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_sub_r  <= 8'h00;
      wr_len_r  <= 5'h00;
      wr_data_r <= '0;
    end
    else
    begin
      wr_stb_r <= 1'b0;
      if (bus_start)
      begin
        state_r  <= ST_RX;
        role_r   <= RO_ADR;
        bitc_r   <= 4'h0;
        cnt_r    <= 5'h00;
        sda_oe_r <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_r  <= ST_IDLE;
        cnt_r    <= 5'h00;
        sda_oe_r <= 1'b0;
      end
      else
        unique case (state_r)
          ST_IDLE, ST_SKIP: ;
          ST_RX:
            if (scl_rise)
            begin
              sh_r   <= {sh_r[6:0], sda_s2_r};
              bitc_r <= bitc_r + 4'h1;
            end
            else if (byte_done)
            begin
              bitc_r <= 4'h0;
              // ack every byte that reaches this point unless the address mismatches
              state_r  <= ST_ACK;
              sda_oe_r <= 1'b1;
              unique case (role_r)
                RO_ADR:
                  if (!adr_hit)
                  begin
                    // mismatch: no ack, wait for start
                    state_r  <= ST_SKIP;
                    sda_oe_r <= 1'b0;
                  end
                  else
                  begin
                    rd_mode_r <= sh_r[0];
                    role_r    <= RO_SUB;
                  end
                RO_SUB:
                begin
                  sub_r  <= sh_r;
                  buf_r  <= '0;
                  cnt_r  <= 5'h00;
                  role_r <= RO_DAT;
                end
                default:
                begin
                  buf_r <= buf_nxt;
                  // count bytes against the register length
                  if (set_done)
                  begin
                    // commit set, clear buffer
                    // dropped bytes must not leak into the next set
                    buf_r     <= '0;
                    wr_stb_r  <= 1'b1;
                    wr_sub_r  <= sub_r;
                    wr_len_r  <= len_w;
                    wr_data_r <= buf_nxt;
                    sub_r     <= sub_r + 8'h01;
                    cnt_r     <= 5'h00;
                  end
                  else
                    cnt_r <= cnt_r + 5'h01;
                end
              endcase
            end
          ST_ACK:
            // low from one falling scl edge to the next
            if (scl_fall)
            begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_RX;
              if (rd_mode_r)
              begin
                state_r  <= ST_TX;
                tx_r     <= tx_byte;
                sda_oe_r <= ~tx_byte[7];
              end
            end
          ST_TX:
            // data changes only at the master's scl falls
            if (scl_fall)
            begin
              if (bitc_r == 4'h7)
              begin
                bitc_r   <= 4'h0;
                sda_oe_r <= 1'b0;
                state_r  <= ST_TXACK;
              end
              else
              begin
                bitc_r   <= bitc_r + 4'h1;
                tx_r     <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
              end
            end
          ST_TXACK:
            if (scl_rise)
            begin
              acked_r <= ~sda_s2_r;
              if (!sda_s2_r)
              begin
                sub_r <= set_done ? sub_r + 8'h01 : sub_r;
                cnt_r <= set_done ? 5'h00 : cnt_r + 5'h01;
              end
            end
            else if (scl_fall)
            begin
              state_r  <= acked_r ? ST_TX : ST_SKIP;
              tx_r     <= tx_byte;
              sda_oe_r <= acked_r & ~tx_byte[7];
            end
          default:
            state_r <= ST_IDLE;
        endcase
    end

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = sda_oe_r;
  assign wr_stb       = wr_stb_r;
  assign wr_sub       = wr_sub_r;
  assign wr_len       = wr_len_r;
  assign wr_data      = wr_data_r;
  assign rd_sub       = sub_r;
  assign rd_idx       = cnt_r[4:2];
  assign dev_addr     = addr_r;
endmodule // isr_dev

/* File: isr_host.sv */
// i2c bus master driven by byte-level commands over apb
`timescale 1ns/1ps
module isr_host
  import isr_pkg::*;
#(
  parameter logic [15:0] QTR_DEF = SCL_QTR
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // bus
  isr_if.host              bus
);
  import isr_pkg::*;

  isr_op_e     op_r;
  logic        busy_r;
  logic [1:0]  qph_r;
  logic [3:0]  bitn_r;
  logic [15:0] qcnt_r;
  logic [15:0] div_r;
  logic [8:0]  txv_r;
  logic [8:0]  rxv_r;
  logic        scl_oe_r;
  logic        sda_oe_r;
  logic        sda_s1_r, sda_s2_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;

  wire acc_first = psel & penable & ~pready_r;
  wire acc_done  = psel & penable & pready_r;
  wire hit_cmd   = (paddr == HOST_CMD);
  wire hit_stat  = (paddr == HOST_STAT);
  wire hit_div   = (paddr == HOST_DIV);
  wire unmapped  = ~(hit_cmd | hit_stat | hit_div);
  // a command written while busy is ignored
  wire cmd_go    = acc_done & pwrite & hit_cmd & ~busy_r;
  wire tick      = busy_r && (qcnt_r == 16'h0000);
  wire last_q    = tick && (qph_r == 2'h3);
  wire byte_op   = (op_r == OP_WRITE) || (op_r == OP_READ);

  wire [31:0] stat_w = {16'h0000, rxv_r[8:1], 6'h00,
                        ~rxv_r[0], busy_r};
  wire [31:0] rd_mux = hit_cmd  ? 32'h0 :
                       hit_stat ? stat_w :
                       hit_div  ? {16'h0000, div_r} : 32'h0;

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
      div_r     <= QTR_DEF;
      sda_s1_r  <= 1'b1;
      sda_s2_r  <= 1'b1;
    end
    else
    begin
      // one wait state, then the answer
      pready_r  <= acc_first;
      pslverr_r <= acc_first & unmapped;
      prdata_r  <= acc_first ? rd_mux : 32'h0;
      if (acc_done && pwrite && hit_div && pwdata[15:0] != 16'h0000)
        div_r <= pwdata[15:0];
      sda_s1_r <= bus.sda;
      sda_s2_r <= sda_s1_r;
    end

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      op_r     <= OP_STOP;
      busy_r   <= 1'b0;
      qph_r    <= 2'h0;
      bitn_r   <= 4'h0;
      qcnt_r   <= 16'h0000;
      txv_r    <= 9'h1ff;
      rxv_r    <= 9'h1ff;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (cmd_go)
    begin
      // frames are built by command order
      op_r   <= isr_op_e'(pwdata[CMD_OP_LSB +: 2]);
      busy_r <= 1'b1;
      qph_r  <= 2'h0;
      bitn_r <= 4'h0;
      qcnt_r <= div_r - 16'h0001;
      // nack sent by the ninth bit of a read
      txv_r  <= (pwdata[CMD_OP_LSB +: 2] == OP_READ) ?
                {8'hff, pwdata[CMD_NACK_BIT]} :
                {pwdata[CMD_DATA_LSB +: 8], 1'b1};
    end
    else if (busy_r)
    begin
      qcnt_r <= tick ? div_r - 16'h0001 : qcnt_r - 16'h0001;
      if (tick)
      begin
        qph_r <= qph_r + 2'h1;
        unique case (op_r)
          // sda moves while scl high only here and in stop
          OP_START:
            unique case (qph_r)
              2'h0: sda_oe_r <= 1'b0;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b1;
              2'h3: scl_oe_r <= 1'b1;
            endcase
          OP_STOP:
            unique case (qph_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b0;
              2'h3: ;
            endcase
          default:
            unique case (qph_r)
              // msb first, data changes with scl low
              2'h0: sda_oe_r <= ~txv_r[8];
              2'h1: scl_oe_r <= 1'b0;
              2'h2: rxv_r    <= {rxv_r[7:0], sda_s2_r};
              2'h3:
              begin
                scl_oe_r <= 1'b1;
                txv_r    <= {txv_r[7:0], 1'b1};
                bitn_r   <= bitn_r + 4'h1;
              end
            endcase
        endcase
        if (last_q && (!byte_op || bitn_r == 4'h8))
          busy_r <= 1'b0;
      end
    end

  // scl period is four times the divider
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe_r;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_oe_r;
  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
endmodule // isr_host

/* File: isr_props.sv */
// concurrent checks on the two-wire bus joining master and register port
`timescale 1ns/1ps
module isr_props
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bus levels and enables
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe
);
  logic [3:0] lo_cnt_r;
  logic [3:0] lo_cnt_nxt;
  // saturates so a long idle low phase cannot wrap back into range
  assign lo_cnt_nxt = scl ? 4'h0 :
                      (lo_cnt_r == 4'hf) ? lo_cnt_r : lo_cnt_r + 4'h1;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      lo_cnt_r <= 4'h0;
    else
      lo_cnt_r <= lo_cnt_nxt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_hold_high;
    scl && $past(scl) |-> $stable(s_sda_oe);
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("port changed sda while scl high");
  property p_edge_timing;
    $changed(s_sda_oe) |-> lo_cnt_r inside {[4'h1:4'h8]};
  endproperty
  a_edge_timing: assert property (p_edge_timing)
    else $error("port sda change outside early scl low");
  // no wait states: any change of the port's sda comes early in an scl low phase
  property p_scl_free;
    $changed(s_sda_oe) |-> !scl && lo_cnt_r <= 4'h4;
  endproperty
  a_scl_free: assert property (p_scl_free)
    else $error("port answered late in scl low phase");
  property p_start_master;
    $fell(sda) && scl && $past(scl) |-> m_sda_oe && !s_sda_oe;
  endproperty
  a_start_master: assert property (p_start_master)
    else $error("start not made by master");
  property p_stop_master;
    $rose(sda) && scl && $past(scl) |-> $past(m_sda_oe) && !$past(s_sda_oe);
  endproperty
  a_stop_master: assert property (p_stop_master)
    else $error("stop not made by master");
  property p_stop_idle;
    $rose(sda) && scl && $past(scl) |=> !s_sda_oe [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("port drove sda after stop");
  property p_master_high;
    scl && $past(scl) && $changed(m_sda_oe) |-> !s_sda_oe && !$past(s_sda_oe);
  endproperty
  a_master_high: assert property (p_master_high)
    else $error("master moved sda in high phase over port");
  property p_reset_idle;
    $rose(resetn) |-> !s_sda_oe && !m_sda_oe && !m_scl_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("bus not released after reset");

  c_start: cover property ($fell(sda) && scl && $past(scl));
  c_stop: cover property ($rose(sda) && scl && $past(scl));
  c_ack: cover property ($rose(s_sda_oe));
endmodule // isr_props

/* File: i2c_slave_register_access_tb_top.sv */
// self-checking bench joining the bus master and the register port
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("Error %0t: got %h want %h", $time, (a), (b)); \
    end \
  end
module i2c_slave_register_access_tb_top;
  import isr_pkg::*;
  localparam logic [6:0] NEW_ADDR = 7'h33;
  localparam logic [7:0] WS[5] = '{8'h20, 8'h22, 8'h29, 8'h36, 8'hff};
  localparam int         WN[5] = '{3, 6, 19, 20, 4};
  localparam logic [7:0] RS[4] = '{8'h02, 8'h21, 8'h29, 8'h24};
  localparam int         RN[4] = '{3, 4, 8, 4};
  logic         clk     = 1'b0;
  logic         resetn  = 1'b0;
  logic         adr_sel = 1'b1;
  logic [7:0]   paddr   = 8'h00;
  logic         psel    = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite  = 1'b0;
  logic [31:0]  pwdata  = 32'h0;
  logic [31:0]  prdata, rd_word, rdat, st;
  logic         pready, pslverr, rerr, wr_stb;
  logic [7:0]   wr_sub, rd_sub;
  logic [4:0]   wr_len;
  logic [159:0] wr_data;
  logic [2:0]   rd_idx;
  logic [5:0]   rd_width;
  logic [6:0]   dev_addr;
  logic [7:0]   bq[$];
  logic [172:0] got[$], exq[$];
  int           err_total = 0, num_checks = 0;

  isr_if bus_if ();
  isr_dev isr_dev_i (.clk(clk), .resetn(resetn), .bus(bus_if),
    .adr_sel(adr_sel), .wr_stb(wr_stb), .wr_sub(wr_sub), .wr_len(wr_len),
    .wr_data(wr_data), .rd_sub(rd_sub), .rd_idx(rd_idx), .rd_word(rd_word),
    .rd_width(rd_width), .dev_addr(dev_addr));
  isr_host #(.QTR_DEF(16'h0006)) isr_host_i (.clk(clk), .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus(bus_if));
  isr_props isr_props_i (.clk(clk), .resetn(resetn), .scl(bus_if.scl),
    .sda(bus_if.sda), .m_scl_oe(bus_if.m_scl_oe),
    .m_sda_oe(bus_if.m_sda_oe), .s_sda_oe(bus_if.s_sda_oe));

  function automatic logic [31:0] reg_val(logic [7:0] s, logic [2:0] i);
    return {s ^ 8'h5a, ~s, 5'(i), 3'h6, s};
  endfunction
  function automatic logic [5:0] width_of(logic [7:0] s);
    return (s < 8'h20) ? 6'h08 : (s == 8'h21) ? 6'h10 : 6'h20;
  endfunction
  function automatic int len_of(logic [7:0] s);
    return (s < 8'h20) ? 1 : (s >= 8'h29 && s <= 8'h36) ? 20 : 4;
  endfunction
  // byte registers advance the pointer, wider ones walk their words
  function automatic logic [7:0] exp_byte(logic [7:0] s, int k);
    logic [7:0]  r;
    logic [31:0] w;
    r = (s < 8'h20) ? s + 8'(k) : s;
    w = reg_val(r, 3'(k / 4)) & 32'((64'h1 << width_of(r)) - 64'h1);
    return (s < 8'h20) ? w[7:0] : w[8*(3-k%4) +: 8];
  endfunction

  assign rd_word  = reg_val(rd_sub, rd_idx);
  assign rd_width = width_of(rd_sub);

  initial
    forever #12.5 clk = ~clk;

  always @(posedge clk)
    if (wr_stb === 1'b1)
      got.push_back({wr_sub, wr_len, wr_data});

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // waits on pready with no limit, only the watchdog ends a hang
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic op(input isr_op_e o, input logic [7:0] d, input logic nk);
    apb(1'b1, HOST_CMD, {15'h0, nk, d, 6'h0, o});
    do
    begin
      apb(1'b0, HOST_STAT, 32'h0);
      st = rdat;
    end while (st[STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic expect_sets(input logic [7:0] s);
    logic [159:0] acc;
    int           k;
    acc = '0;
    k = 0;
    foreach (bq[i])
    begin
      acc = {acc[151:0], bq[i]};
      k++;
      if (k == len_of(s))
      begin
        exq.push_back({s, 5'(k), acc});
        s++;
        acc = '0;
        k = 0;
      end
    end
  endtask

  task automatic cmp_sets(input string name);
    `CHK(got.size(), exq.size())
    foreach (exq[i])
      if (i < got.size())
        `CHK(got[i], exq[i])
    got.delete();
    exq.delete();
    bq.delete();
    $display("test %s done", name);
  endtask

  task automatic head(input logic [6:0] a, input logic [7:0] s,
                      input logic ak);
    op(OP_START, 8'h00, 1'b0);
    op(OP_WRITE, {a, 1'b0}, 1'b0);
    `CHK(st[STAT_ACK_BIT], ak)
    if (ak)
    begin
      op(OP_WRITE, s, 1'b0);
      `CHK(st[STAT_ACK_BIT], 1'b1)
      foreach (bq[i])
      begin
        op(OP_WRITE, bq[i], 1'b0);
        `CHK(st[STAT_ACK_BIT], 1'b1)
      end
    end
  endtask

  task automatic wr_frame(input logic [6:0] a, input logic [7:0] s,
                          input logic ak);
    head(a, s, ak);
    op(OP_STOP, 8'h00, 1'b0);
  endtask

  // repeated start after the subaddress and any queued data bytes, last byte refused by master
  task automatic rd_frame(input logic [7:0] s, input int n);
    head(ADDR_STRAP_HI, s, 1'b1);
    op(OP_START, 8'h00, 1'b0);
    op(OP_WRITE, {ADDR_STRAP_HI, 1'b1}, 1'b0);
    `CHK(st[STAT_ACK_BIT], 1'b1)
    for (int k = 0; k < n; k++)
    begin
      op(OP_READ, 8'h00, k == n - 1);
      `CHK(st[15:8], exp_byte(s, k))
    end
    op(OP_STOP, 8'h00, 1'b0);
  endtask

  initial
  begin
    repeat (80000) @(posedge clk);
    err_total++;
    close_out;
  end

  initial
  begin
    logic [7:0] s;
    void'($urandom(1));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(dev_addr, ADDR_STRAP_HI)
    apb(1'b1, HOST_DIV, 32'h0);
    apb(1'b0, HOST_DIV, 32'h0);
    `CHK(rdat[15:0], 16'h0006)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(rerr, 1'b1)
    cmp_sets("host regs");
    bq.push_back(8'h11);
    wr_frame(ADDR_STRAP_LO, 8'h01, 1'b0);
    cmp_sets("foreign address");
    s = 8'($urandom % 32);
    bq.push_back(8'($urandom));
    expect_sets(s);
    wr_frame(ADDR_STRAP_HI, s, 1'b1);
    cmp_sets("single byte");
    repeat (16) bq.push_back(8'($urandom));
    expect_sets(8'h05);
    wr_frame(ADDR_STRAP_HI, 8'h05, 1'b1);
    cmp_sets("sixteen");
    foreach (WS[i])
    begin
      repeat (WN[i]) bq.push_back(8'($urandom));
      expect_sets(WS[i]);
      wr_frame(ADDR_STRAP_HI, WS[i], 1'b1);
      cmp_sets("word sets");
    end
    foreach (RS[i])
    begin
      if (i == 3)
        repeat (2) bq.push_back(8'($urandom));
      expect_sets(RS[i]);
      rd_frame(RS[i], RN[i]);
      cmp_sets("reads");
    end
    bq = {8'h00, 8'h00, 8'h00, 8'(NEW_ADDR)};
    expect_sets(SUB_NEW_ADDR);
    wr_frame(ADDR_STRAP_HI, SUB_NEW_ADDR, 1'b1);
    cmp_sets("locked");
    `CHK(dev_addr, ADDR_STRAP_HI)
    bq = {8'hf9, 8'ha5, 8'ha5, 8'ha5};
    expect_sets(SUB_UNLOCK);
    wr_frame(ADDR_STRAP_HI, SUB_UNLOCK, 1'b1);
    cmp_sets("unlock");
    bq = {8'h00, 8'h00, 8'h00, 8'(NEW_ADDR)};
    expect_sets(SUB_NEW_ADDR);
    wr_frame(ADDR_STRAP_HI, SUB_NEW_ADDR, 1'b1);
    cmp_sets("new address");
    bq.push_back(8'h42);
    wr_frame(ADDR_STRAP_HI, 8'h03, 1'b0);
    cmp_sets("old address");
    `CHK(dev_addr, NEW_ADDR)
    bq.push_back(8'h42);
    expect_sets(8'h03);
    wr_frame(NEW_ADDR, 8'h03, 1'b1);
    cmp_sets("moved");
    adr_sel <= 1'b0;
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(dev_addr, ADDR_STRAP_LO)
    bq.push_back(8'($urandom));
    expect_sets(8'h1f);
    wr_frame(ADDR_STRAP_LO, 8'h1f, 1'b1);
    cmp_sets("strap low");
    close_out;
  end
endmodule // i2c_slave_register_access_tb_top
